// File: iep_pkg.sv
// constants, carrier types and shared decode for the interrupt enable/priority bank
package iep_pkg;
  localparam int AW = 6;
  localparam int DW = 32;
  localparam int RW = 16;
  localparam int LW = 3;
  localparam int BYTE_W = 8;
  localparam int NSRC = 48;
  localparam int NPRI = 8;
  localparam int FLD_STRIDE = 4;
  localparam int FLD_PER_WORD = 4;
  // byte offsets of the five registers
  localparam logic [AW-1:0] OFS_EN2 = 6'h00;
  localparam logic [AW-1:0] OFS_EN3 = 6'h04;
  localparam logic [AW-1:0] OFS_EN4 = 6'h08;
  localparam logic [AW-1:0] OFS_PR0 = 6'h0C;
  localparam logic [AW-1:0] OFS_PR1 = 6'h10;
  // register select codes
  localparam logic [2:0] SEL_EN2 = 3'h0;
  localparam logic [2:0] SEL_EN3 = 3'h1;
  localparam logic [2:0] SEL_EN4 = 3'h2;
  localparam logic [2:0] SEL_PR0 = 3'h3;
  localparam logic [2:0] SEL_PR1 = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;
  // implemented bits and reset values
  localparam logic [RW-1:0] EN2_MASK = 16'hDFFF;
  localparam logic [RW-1:0] EN3_MASK = 16'hBFFF;
  localparam logic [RW-1:0] EN4_MASK = 16'h00F7;
  localparam logic [RW-1:0] PR_MASK = 16'h7777;
  localparam logic [RW-1:0] EN_RST = 16'h0000;
  localparam logic [RW-1:0] PR_RST = 16'h4444;
  localparam logic [LW-1:0] LVL_OFF = 3'h0;
  localparam logic [LW-1:0] LVL_TOP = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] STRB_ALL = 2'h3;
  // bit positions: word bases in the flat request vector, bits inside the enable words and priority word one
  localparam int BASE_EN2 = 0;
  localparam int BASE_EN3 = 16;
  localparam int BASE_EN4 = 32;
  localparam int EN3_I2CB_MST = 2;
  localparam int EN3_I2CB_SLV = 1;
  localparam int EN3_TMRG = 0;
  localparam int EN2_CANA_RX = 2;
  localparam int EN2_SPIB_EVT = 1;
  localparam int EN2_SPIB_ERR = 0;
  localparam int EN2_CAPC = 5;
  localparam int EN2_DMAD = 4;
  localparam int PR1_TMRB_LSB = 12;

  typedef struct packed {
    logic awvalid;
    logic [AW-1:0] awaddr;
    logic wvalid;
    logic [DW-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AW-1:0] araddr;
    logic rready;
  } iep_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DW-1:0] rdata;
    logic [1:0] rresp;
  } iep_axi_rsp_t;

  typedef struct packed {
    logic i2c_b_master_evt_en;
    logic i2c_b_slave_evt_en;
    logic timer_g_irq_en;
    logic can_a_rx_ready_en;
    logic spi_b_event_en;
    logic spi_b_error_en;
    logic capture_c_irq_en;
    logic dma_ch_d_done_en;
  } iep_named_t;

  typedef struct packed {
    logic [RW-1:0] en2;
    logic [RW-1:0] en3;
    logic [RW-1:0] en4;
    logic [RW-1:0] pr0;
    logic [RW-1:0] pr1;
  } iep_regs_t;

  typedef struct packed {
    iep_regs_t regs;
    logic awHeld;
    logic [AW-1:0] awAddr;
    logic wHeld;
    logic [RW-1:0] wData;
    logic [1:0] wStrb;
    iep_axi_rsp_t rsp;
    logic [NSRC-1:0] gated;
    logic [NPRI*LW-1:0] levels;
    logic winValid;
    logic [2:0] winIdx;
    logic [LW-1:0] winLevel;
    iep_named_t named;
    logic [LW-1:0] tmrBLevel;
  } iep_state_t;

  localparam iep_regs_t REGS_RST = '{en2: EN_RST, en3: EN_RST, en4: EN_RST,
                                     pr0: PR_RST, pr1: PR_RST};
  localparam iep_axi_rsp_t RSP_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                       default: '0};
  localparam iep_state_t ST_RST = '{regs: REGS_RST, rsp: RSP_RST, default: '0};

  // word decode shared by the read and write paths
  function automatic logic [2:0] regSel(input logic [AW-1:0] a);
    case ({a[AW-1:2], 2'h0})
      OFS_EN2: regSel = SEL_EN2;
      OFS_EN3: regSel = SEL_EN3;
      OFS_EN4: regSel = SEL_EN4;
      OFS_PR0: regSel = SEL_PR0;
      OFS_PR1: regSel = SEL_PR1;
      default: regSel = SEL_NONE;
    endcase
  endfunction

  // byte-lane merge limited to implemented bits
  function automatic logic [RW-1:0] mergeWord(input logic [RW-1:0] old,
    input logic [RW-1:0] data, input logic [1:0] strb, input logic [RW-1:0] mask);
    logic [RW-1:0] be;
    be = {{BYTE_W{strb[1]}}, {BYTE_W{strb[0]}}} & mask;
    mergeWord = (old & ~be) | (data & be);
  endfunction
endpackage

// File: iep_arbiter.sv
// priority pick among tagged requests: highest level wins, lowest index on a tie
`timescale 1ns/10ps
`default_nettype none
module iep_arbiter #(
  parameter int N = 8,
  parameter int LW = 3,
  parameter int IW = 3
) (
  input wire logic [N-1:0] req,
  input wire logic [N*LW-1:0] level,
  output logic hit,
  output logic [IW-1:0] idx,
  output logic [LW-1:0] lvl
);
  // scan all sources; a level of zero can never beat the empty start
  always_comb
  begin
    lvl = '0;
    idx = '0;
    for (int i = 0; i < N; i++)
    begin
      if (req[i] && (level[i*LW +: LW] > lvl))
      begin
        lvl = level[i*LW +: LW];
        idx = IW'(i);
      end
    end
    hit = (lvl != '0);
  end
endmodule // iep_arbiter
`default_nettype wire

// File: iep_bank.sv
// interrupt source enable and priority register bank with AXI4-Lite access
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module iep_bank (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire iep_pkg::iep_axi_req_t axiReq,
  output var iep_pkg::iep_axi_rsp_t axiRsp,
  input wire logic [iep_pkg::NSRC-1:0] srcPend,
  input wire logic [iep_pkg::NPRI-1:0] priPend,
  input wire logic [iep_pkg::NPRI-1:0] priEn,
  output var logic [iep_pkg::NSRC-1:0] srcGated,
  output var iep_pkg::iep_named_t namedGated,
  output var logic [iep_pkg::NPRI*iep_pkg::LW-1:0] srcLevel,
  output var logic winValid,
  output var logic [2:0] winIdx,
  output var logic [iep_pkg::LW-1:0] winLevel,
  output var logic [iep_pkg::LW-1:0] timerBLevel
);
  localparam int LW = iep_pkg::LW;
  localparam int NPRI = iep_pkg::NPRI;

  iep_pkg::iep_state_t st_q;
  iep_pkg::iep_state_t st_d;
  logic awTake;
  logic wTake;
  logic arTake;
  logic doWrite;
  logic [2:0] wrSel;
  logic [2:0] rdSel;
  logic [NPRI-1:0] priReq;
  logic [NPRI*LW-1:0] priLvl;
  logic [iep_pkg::NSRC-1:0] enFlat;
  logic arbHit;
  logic [2:0] arbIdx;
  logic [LW-1:0] arbLvl;
  logic topReq;
  logic [LW-1:0] maxLvl;

  // read mux over the five words, upper lanes zero
  function automatic logic [iep_pkg::DW-1:0] rdWord(input iep_pkg::iep_regs_t r,
    input logic [2:0] sel);
    logic [iep_pkg::RW-1:0] w;
    case (sel)
      iep_pkg::SEL_EN2: w = r.en2;
      iep_pkg::SEL_EN3: w = r.en3;
      iep_pkg::SEL_EN4: w = r.en4;
      iep_pkg::SEL_PR0: w = r.pr0;
      iep_pkg::SEL_PR1: w = r.pr1;
      default: w = '0;
    endcase
    rdWord = iep_pkg::DW'(w);
  endfunction

  // bus handshakes and decode
  assign awTake = axiReq.awvalid & st_q.rsp.awready;
  assign wTake = axiReq.wvalid & st_q.rsp.wready;
  assign arTake = axiReq.arvalid & st_q.rsp.arready;
  assign doWrite = st_q.awHeld & st_q.wHeld & ~st_q.rsp.bvalid;
  assign wrSel = iep_pkg::regSel(st_q.awAddr);
  assign rdSel = iep_pkg::regSel(axiReq.araddr);

  // request qualification inputs
  assign enFlat = {st_q.regs.en4, st_q.regs.en3, st_q.regs.en2};
  assign priReq = priPend & priEn;

  // unpack the eight 3-bit priority fields, four per word
  genvar g;
  generate
    for (g = 0; g < NPRI; g++)
    begin : g_fld
      localparam int FI = g % iep_pkg::FLD_PER_WORD;
      if (g < iep_pkg::FLD_PER_WORD)
      begin : g_lo
        assign priLvl[g*LW +: LW] = st_q.regs.pr0[FI*iep_pkg::FLD_STRIDE +: LW];
      end
      else
      begin : g_hi
        assign priLvl[g*LW +: LW] = st_q.regs.pr1[FI*iep_pkg::FLD_STRIDE +: LW];
      end
    end
  endgenerate

  // pick the most urgent tagged request
  iep_arbiter #(
    .N(NPRI),
    .LW(LW),
    .IW(3)
  ) u_arb (
    .req(priReq),
    .level(priLvl),
    .hit(arbHit),
    .idx(arbIdx),
    .lvl(arbLvl)
  );

  // next state: bus slave, register writes, qualified outputs
  always_comb
  begin
    st_d = st_q;
    if (clkEn)
    begin
      // address and data are caught independently
      if (awTake)
      begin
        st_d.awHeld = 1'b1;
        st_d.awAddr = axiReq.awaddr;
      end
      if (wTake)
      begin
        st_d.wHeld = 1'b1;
        st_d.wData = axiReq.wdata[iep_pkg::RW-1:0];
        st_d.wStrb = axiReq.wstrb[1:0];
      end
      if (st_q.rsp.bvalid && axiReq.bready)
      begin
        st_d.rsp.bvalid = 1'b0;
      end
      // write commits once both halves are held and no write response is pending
      if (doWrite)
      begin
        st_d.awHeld = 1'b0;
        st_d.wHeld = 1'b0;
        st_d.rsp.bvalid = 1'b1;
        st_d.rsp.bresp = iep_pkg::RESP_OKAY;
        case (wrSel)
          iep_pkg::SEL_EN2:
          begin
            st_d.regs.en2 = iep_pkg::mergeWord(st_q.regs.en2, st_q.wData, st_q.wStrb,
              iep_pkg::EN2_MASK);
          end
          iep_pkg::SEL_EN3:
          begin
            st_d.regs.en3 = iep_pkg::mergeWord(st_q.regs.en3, st_q.wData, st_q.wStrb,
              iep_pkg::EN3_MASK);
          end
          iep_pkg::SEL_EN4:
          begin
            st_d.regs.en4 = iep_pkg::mergeWord(st_q.regs.en4, st_q.wData, st_q.wStrb,
              iep_pkg::EN4_MASK);
          end
          iep_pkg::SEL_PR0:
          begin
            st_d.regs.pr0 = iep_pkg::mergeWord(st_q.regs.pr0, st_q.wData, st_q.wStrb,
              iep_pkg::PR_MASK);
          end
          iep_pkg::SEL_PR1:
          begin
            st_d.regs.pr1 = iep_pkg::mergeWord(st_q.regs.pr1, st_q.wData, st_q.wStrb,
              iep_pkg::PR_MASK);
          end
          default:
          begin
            st_d.rsp.bresp = iep_pkg::RESP_SLVERR;
          end
        endcase
      end
      st_d.rsp.awready = ~st_d.awHeld;
      st_d.rsp.wready = ~st_d.wHeld;
      // read answers one cycle after the address is taken
      if (st_q.rsp.rvalid && axiReq.rready)
      begin
        st_d.rsp.rvalid = 1'b0;
      end
      if (arTake)
      begin
        st_d.rsp.rvalid = 1'b1;
        st_d.rsp.rdata = rdWord(st_q.regs, rdSel);
        st_d.rsp.rresp = (rdSel == iep_pkg::SEL_NONE) ? iep_pkg::RESP_SLVERR
                                                    : iep_pkg::RESP_OKAY;
      end
      st_d.rsp.arready = ~st_d.rsp.rvalid;
      // enable gating of every source request
      st_d.gated = srcPend & enFlat;
      st_d.named.i2c_b_master_evt_en = srcPend[iep_pkg::BASE_EN3 + iep_pkg::EN3_I2CB_MST]
        & st_q.regs.en3[iep_pkg::EN3_I2CB_MST];
      st_d.named.i2c_b_slave_evt_en = srcPend[iep_pkg::BASE_EN3 + iep_pkg::EN3_I2CB_SLV]
        & st_q.regs.en3[iep_pkg::EN3_I2CB_SLV];
      st_d.named.timer_g_irq_en = srcPend[iep_pkg::BASE_EN3 + iep_pkg::EN3_TMRG]
        & st_q.regs.en3[iep_pkg::EN3_TMRG];
      st_d.named.can_a_rx_ready_en = srcPend[iep_pkg::BASE_EN2 + iep_pkg::EN2_CANA_RX]
        & st_q.regs.en2[iep_pkg::EN2_CANA_RX];
      st_d.named.spi_b_event_en = srcPend[iep_pkg::BASE_EN2 + iep_pkg::EN2_SPIB_EVT]
        & st_q.regs.en2[iep_pkg::EN2_SPIB_EVT];
      st_d.named.spi_b_error_en = srcPend[iep_pkg::BASE_EN2 + iep_pkg::EN2_SPIB_ERR]
        & st_q.regs.en2[iep_pkg::EN2_SPIB_ERR];
      st_d.named.capture_c_irq_en = srcPend[iep_pkg::BASE_EN2 + iep_pkg::EN2_CAPC]
        & st_q.regs.en2[iep_pkg::EN2_CAPC];
      st_d.named.dma_ch_d_done_en = srcPend[iep_pkg::BASE_EN2 + iep_pkg::EN2_DMAD]
        & st_q.regs.en2[iep_pkg::EN2_DMAD];
      // levels and arbitration result
      st_d.levels = priLvl;
      st_d.winValid = arbHit;
      st_d.winIdx = arbIdx;
      st_d.winLevel = arbLvl;
      st_d.tmrBLevel = st_q.regs.pr1[iep_pkg::PR1_TMRB_LSB +: LW];
    end
  end

  // state register; reset loads the documented defaults
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= iep_pkg::ST_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign axiRsp = st_q.rsp;
  assign srcGated = st_q.gated;
  assign namedGated = st_q.named;
  assign srcLevel = st_q.levels;
  assign winValid = st_q.winValid;
  assign winIdx = st_q.winIdx;
  assign winLevel = st_q.winLevel;
  assign timerBLevel = st_q.tmrBLevel;

  // checker helpers: any top-level request, independent maximum
  always_comb
  begin
    topReq = 1'b0;
    maxLvl = iep_pkg::LVL_OFF;
    for (int i = 0; i < NPRI; i++)
    begin
      if (priReq[i] && priLvl[i*LW +: LW] == iep_pkg::LVL_TOP)
      begin
        topReq = 1'b1;
      end
      if (priReq[i] && priLvl[i*LW +: LW] > maxLvl)
      begin
        maxLvl = priLvl[i*LW +: LW];
      end
    end
  end

  // gated vector follows request and enable one cycle later
  gate_follow_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn |=> srcGated == $past(srcPend & enFlat))
  else $error("gated request does not match request and enable");

  // a pending enabled level 7 request always makes the winning level 7
  top_wins_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn && topReq |=> winValid && winLevel == iep_pkg::LVL_TOP)
  else $error("level 7 request did not win");

  // a winner never carries level zero, and its field really holds that level
  zero_never_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn ##1 winValid |-> winLevel != iep_pkg::LVL_OFF
      && (($past(priReq) >> winIdx) & 8'h01) == 8'h01 && srcLevel[winIdx*LW +: LW] == winLevel)
  else $error("winner has level zero or wrong source");

  // winning level equals the largest requested level
  level_order_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn |=> winLevel == $past(maxLvl) && winValid == ($past(maxLvl) != 3'h0))
  else $error("winning level is not the highest one");

  // first edge after release shows reset defaults
  reset_default_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(resetn) |-> st_q.regs == iep_pkg::REGS_RST && !winValid)
  else $error("registers not at defaults after reset");

  // group three named requests
  i2c_timer_map_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn |=> namedGated.i2c_b_master_evt_en == srcGated[18]
      && namedGated.i2c_b_slave_evt_en == srcGated[17]
      && namedGated.timer_g_irq_en == srcGated[16])
  else $error("group three bit mapping wrong");

  // group two low named requests
  can_spi_map_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn |=> namedGated.can_a_rx_ready_en == $past(srcPend[2] & st_q.regs.en2[2])
      && namedGated.spi_b_event_en == srcGated[1]
      && namedGated.spi_b_error_en == srcGated[0])
  else $error("group two low bit mapping wrong");

  // group two capture and dma requests
  cap_dma_map_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn |=> namedGated.capture_c_irq_en == $past(srcPend[5] & st_q.regs.en2[5])
      && namedGated.dma_ch_d_done_en == $past(srcPend[4] & st_q.regs.en2[4]))
  else $error("capture or dma bit mapping wrong");

  // timer level tracks bits 14-12 of priority word one
  timer_level_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn |=> timerBLevel == $past(st_q.regs.pr1[iep_pkg::PR1_TMRB_LSB +: LW])
      && timerBLevel == srcLevel[(NPRI-1)*LW +: LW])
  else $error("timer level field misplaced");

  // upper read lanes are zero and unimplemented bits of en4 and pr1 stay zero
  reserved_zero_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    axiRsp.rvalid |-> axiRsp.rdata[31:16] == 16'h0000
      && (st_q.regs.en4 & ~iep_pkg::EN4_MASK) == 16'h0000
      && (st_q.regs.pr1 & ~iep_pkg::PR_MASK) == 16'h0000)
  else $error("reserved bit set");

  // full-lane write to priority word one lands masked one cycle later
  write_back_a:
  assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn && doWrite && wrSel == iep_pkg::SEL_PR1 && st_q.wStrb == iep_pkg::STRB_ALL
      |=> st_q.regs.pr1 == ($past(st_q.wData) & iep_pkg::PR_MASK) && axiRsp.bvalid)
  else $error("priority write not stored");
endmodule // iep_bank
`default_nettype wire

// File: iep_core_model.sv
// behavioural model of the core side that takes the offered winner each cycle
`timescale 1ns/10ps
`default_nettype none
module iep_core_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic winValid,
  input wire logic [2:0] winIdx,
  input wire logic [2:0] winLevel,
  output logic takenValid,
  output logic [2:0] takenIdx,
  output logic [2:0] takenLevel
);
  // latch the winner; an idle offer leaves level zero
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      takenValid <= 1'b0;
      takenIdx <= 3'h0;
      takenLevel <= 3'h0;
    end
    else
    begin
      takenValid <= winValid;
      takenIdx <= winValid ? winIdx : 3'h0;
      takenLevel <= winValid ? winLevel : 3'h0;
    end
  end
endmodule // iep_core_model
`default_nettype wire

// File: iep_bank_bench.sv
// self-checking bench for the enable and priority bank over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
module iep_bank_bench;
  logic ref_clk;
  logic resetn;
  logic clkEn;
  iep_pkg::iep_axi_req_t axiReq;
  iep_pkg::iep_axi_rsp_t axiRsp;
  logic [iep_pkg::NSRC-1:0] srcPend;
  logic [7:0] priPend;
  logic [7:0] priEn;
  logic [iep_pkg::NSRC-1:0] srcGated;
  iep_pkg::iep_named_t namedGated;
  logic [23:0] srcLevel;
  logic winValid;
  logic [2:0] winIdx;
  logic [2:0] winLevel;
  logic [2:0] timerBLevel;
  logic takenValid;
  logic [2:0] takenIdx;
  logic [2:0] takenLevel;
  int failures;
  int checksDone;
  logic [31:0] rdVal;
  logic [1:0] rsp;
  logic [15:0] en2;
  logic [15:0] en3;
  int c;
  localparam logic [5:0] OFS_TAB [5] = '{iep_pkg::OFS_EN2, iep_pkg::OFS_EN3,
    iep_pkg::OFS_EN4, iep_pkg::OFS_PR0, iep_pkg::OFS_PR1};
  localparam logic [15:0] MSK_TAB [5] = '{16'hDFFF, 16'hBFFF, 16'h00F7, 16'h7777, 16'h7777};

  iep_bank u_dut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .srcPend(srcPend),
    .priPend(priPend),
    .priEn(priEn),
    .srcGated(srcGated),
    .namedGated(namedGated),
    .srcLevel(srcLevel),
    .winValid(winValid),
    .winIdx(winIdx),
    .winLevel(winLevel),
    .timerBLevel(timerBLevel)
  );

  iep_core_model u_core (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .winValid(winValid),
    .winIdx(winIdx),
    .winLevel(winLevel),
    .takenValid(takenValid),
    .takenIdx(takenIdx),
    .takenLevel(takenLevel)
  );

  // free-running 125 MHz clock
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  // one counted compare
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // full write: address and data offered together, held until each is taken
  task automatic axiWrite(input logic [5:0] a, input logic [31:0] d);
    logic awT;
    logic wT;
    logic bT;
    int n;
    bT = 1'b0;
    n = 0;
    @(posedge ref_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    while (!bT && n < 64)
    begin
      @(negedge ref_clk);
      awT = axiReq.awvalid && axiRsp.awready;
      wT = axiReq.wvalid && axiRsp.wready;
      bT = axiRsp.bvalid;
      rsp = axiRsp.bresp;
      n++;
      @(posedge ref_clk);
      if (awT)
        axiReq.awvalid <= 1'b0;
      if (wT)
        axiReq.wvalid <= 1'b0;
    end
    axiReq.bready <= 1'b0;
    chk("write answer", 32'h1, 32'(bT));
  endtask

  // full read: address held until taken, data taken with rvalid
  task automatic axiRead(input logic [5:0] a);
    logic arT;
    logic rT;
    int n;
    rT = 1'b0;
    n = 0;
    @(posedge ref_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    while (!rT && n < 64)
    begin
      @(negedge ref_clk);
      arT = axiReq.arvalid && axiRsp.arready;
      rT = axiRsp.rvalid;
      rdVal = axiRsp.rdata;
      rsp = axiRsp.rresp;
      n++;
      @(posedge ref_clk);
      if (arT)
        axiReq.arvalid <= 1'b0;
    end
    axiReq.rready <= 1'b0;
    chk("read answer", 32'h1, 32'(rT));
  endtask

  // read one register and compare data and response
  task automatic rdChk(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er,
    input string what);
    axiRead(a);
    chk(what, exp, rdVal);
    chk("read response", 32'(er), 32'(rsp));
  endtask

  // let a change reach the outputs and the core model
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // report counts and verdict, then stop
  task automatic finish_test();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // cut a hung run short
  initial
  begin
    #100000;
    failures++;
    finish_test();
  end

  // main sequence
  initial
  begin
    failures = 0;
    checksDone = 0;
    resetn = 1'b0;
    clkEn = 1'b1;
    axiReq = '0;
    srcPend = '0;
    priPend = '0;
    priEn = '0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    // reset values, unmapped place
    for (c = 0; c < 5; c++)
      rdChk(OFS_TAB[c], (c < 3) ? 32'h0 : 32'h4444, iep_pkg::RESP_OKAY, "reset value");
    rdChk(6'h14, 32'h0, iep_pkg::RESP_SLVERR, "unmapped read");
    axiWrite(6'h14, 32'hFFFF_FFFF);
    chk("unmapped write", 32'(iep_pkg::RESP_SLVERR), 32'(rsp));
    // every implemented bit writable, the rest stays zero
    for (c = 0; c < 5; c++)
    begin
      axiWrite(OFS_TAB[c], 32'hFFFF_FFFF);
      rdChk(OFS_TAB[c], {16'h0, MSK_TAB[c]}, iep_pkg::RESP_OKAY, "all ones");
      axiWrite(OFS_TAB[c], 32'hA5A5_5A5A);
      rdChk(OFS_TAB[c], {16'h0, 16'h5A5A & MSK_TAB[c]}, iep_pkg::RESP_OKAY, "pattern");
    end
    // enable gating and the named sources, two opposite patterns
    for (c = 0; c < 2; c++)
    begin
      en2 = (c == 0) ? 16'h0035 : 16'h000A;
      en3 = (c == 0) ? 16'h0005 : 16'h0002;
      axiWrite(OFS_TAB[0], {16'h0, en2});
      axiWrite(OFS_TAB[1], {16'h0, en3});
      axiWrite(OFS_TAB[2], 32'h0000_00A1);
      @(posedge ref_clk);
      srcPend <= '1;
      settle();
      chk("gated low", {en3, en2}, srcGated[31:0]);
      chk("gated high", 32'h0000_00A1, 32'(srcGated[47:32]));
      chk("named", 32'({en3[2:0], en2[2:0], en2[5:4]}), 32'(namedGated));
      @(posedge ref_clk);
      srcPend <= 48'h0;
      settle();
      chk("gated idle", 32'h0, srcGated[31:0]);
    end
    // clock enable low freezes the gated outputs, release lets them follow
    @(posedge ref_clk);
    clkEn <= 1'b0;
    srcPend <= '1;
    settle();
    chk("frozen gate", 32'h0, srcGated[31:0]);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    settle();
    chk("thawed gate", {en3, en2}, srcGated[31:0]);
    @(posedge ref_clk);
    srcPend <= 48'h0;
    // ascending codes: code c beats code c-1
    @(posedge ref_clk);
    priPend <= 8'h03;
    priEn <= 8'hFF;
    for (c = 1; c < 8; c++)
    begin
      axiWrite(OFS_TAB[3], 32'((c << 4) | (c - 1)));
      settle();
      chk("field levels", 32'((c << 3) | (c - 1)), 32'(srcLevel[5:0]));
      chk("winner index", 32'h1, 32'(winIdx));
      chk("winner level", 32'(c), 32'(winLevel));
      chk("core level", 32'(c), 32'(takenLevel));
    end
    // level 7 beats every lower level, also from a higher index
    axiWrite(OFS_TAB[3], 32'h0000_6666);
    axiWrite(OFS_TAB[4], 32'h0000_0766);
    @(posedge ref_clk);
    priPend <= 8'hFF;
    settle();
    chk("top index", 32'h6, 32'(winIdx));
    chk("top level", 32'h7, 32'(winLevel));
    chk("core index", 32'h6, 32'(takenIdx));
    // code zero never wins, even when enabled
    axiWrite(OFS_TAB[3], 32'h0);
    axiWrite(OFS_TAB[4], 32'h0);
    settle();
    chk("idle valid", 32'h0, 32'(winValid));
    chk("idle level", 32'h0, 32'(winLevel));
    chk("core idle", 32'h0, 32'(takenValid));
    // second timer field in word one
    axiWrite(OFS_TAB[4], 32'h0000_5000);
    settle();
    chk("timer level", 32'h5, 32'(timerBLevel));
    chk("field seven", 32'h5, 32'(srcLevel[23:21]));
    chk("field four", 32'h0, 32'(srcLevel[14:12]));
    finish_test();
  end
endmodule // iep_bank_bench
`default_nettype wire
